// File: ebi_top.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module ebi_top (
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   // Register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   // Core request, response and mode
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire ebi_pkg::ebi_req_s    req_data,
   output logic                      resp_valid,
   output logic [15:0]               resp_data,
   input  wire logic [1:0]           cpu_mode,
   // Core interrupt side
   input  wire logic                 mimic_irq,
   input  wire logic                 dma_irq,
   input  wire logic                 hdlc_irq,
   input  wire logic [3:1]           irq_clear,
   output logic [3:1]                core_irq,
   output logic                      core_irq0_n,
   // Pins
   input  wire logic                 irq_in_zero_n,
   input  wire logic [3:1]           irq_in_n,
   input  wire logic                 ext_master_request_n,
   input  wire logic                 mem_width_byte_n,
   output logic                      bus_grant_ack_n,
   output logic                      bus_ref_clk,
   output logic                      periph_xfer_clk,
   output logic [23:0]               addr_out,
   input  wire logic [15:0]          data_lines_in,
   output logic [15:0]               data_lines_out,
   output logic                      data_lines_oe,
   output logic                      low_lane_enable_n,
   output logic                      high_lane_enable_n,
   output logic                      mem_read_n,
   output logic                      mem_write_n,
   output logic                      periph_request_n,
   output logic                      periph_read_strobe_n,
   output logic                      periph_write_strobe_n,
   output logic                      opcode_fetch_cycle_n,
   output logic                      bus_oe,
   output logic                      standby_status_n,
   output logic                      halt_status_n
);
   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic [21:0] sy1_q, sy2_q;
   logic [3:0]  sy3_q;
   always_ff @(posedge clk_sys) begin
      sy1_q <= {data_lines_in, mem_width_byte_n, ext_master_request_n,
                irq_in_n, irq_in_zero_n};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q[3:0];
   end
   logic [15:0] din;
   logic        byte_mem, req_pend;
   assign din      = sy2_q[21:6];
   assign byte_mem = !sy2_q[5];
   assign req_pend = !sy2_q[4];

   // ***************************************************
   // Register file
   // ***************************************************
   logic [10:0] ctrl_q, ctrl_d;
   logic [31:0] rdat_q, rdat_d;
   logic [1:0]  ratio;
   logic [1:0]  iodiv;
   logic        io_en;
   ebi_pkg::ebi_state_e st_q, st_d;
   assign ratio = ctrl_q[ebi_pkg::CTRL_RATIO_LSB +: 2];
   assign iodiv = ctrl_q[ebi_pkg::CTRL_IODIV_LSB +: 2];
   assign io_en = ctrl_q[ebi_pkg::CTRL_IOEN_BIT];

   always_comb begin
      ctrl_d = ctrl_q;
      rdat_d = 32'h0000_0000;
      if (reg_wr && reg_addr == ebi_pkg::REG_CTRL) begin
         ctrl_d = reg_wdata[ebi_pkg::CTRL_W-1:0];
      end
      if (reg_rd && reg_addr == ebi_pkg::REG_CTRL) begin
         rdat_d = {21'h0, ctrl_q};
      end else if (reg_rd && reg_addr == ebi_pkg::REG_STAT) begin
         rdat_d = {27'h0, req_pend, st_q == ebi_pkg::ST_GRANT,
                   st_q != ebi_pkg::ST_IDLE, cpu_mode};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_q <= ebi_pkg::CTRL_RST;
         rdat_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         rdat_q <= rdat_d;
      end
   end
   assign reg_rdata = rdat_q;

   // ***************************************************
   // Bus and peripheral clocks
   // ***************************************************
   logic [2:0] ref_half;
   logic       r_rise, p_rise, stp, io_kind;
   always_comb begin
      case (ratio)
         ebi_pkg::RATIO_HALF: ref_half = ebi_pkg::OSC_HALF_CYC << 1;
         ebi_pkg::RATIO_DBL:  ref_half = ebi_pkg::OSC_HALF_CYC >> 1;
         default:             ref_half = ebi_pkg::OSC_HALF_CYC;
      endcase
   end

   ebi_div #(.CNT_W(3)) u_ref (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .en      (1'b1),
      .half    (ref_half),
      .clk_out (bus_ref_clk),
      .rise    (r_rise)
   );

   ebi_div #(.CNT_W(3)) u_io (
      .clk_sys (clk_sys),
      .rstn    (rstn || 1'b0),
      .en      (r_rise && io_en),
      .half    ({1'b0, iodiv} + 3'h1),
      .clk_out (periph_xfer_clk),
      .rise    (p_rise)
   );

   // ***************************************************
   // Request buffer
   // ***************************************************
   ebi_pkg::ebi_req_s buf_data, cur_q, cur_d;
   logic              buf_v, buf_pop;
   assign buf_pop = st_q == ebi_pkg::ST_IDLE && !req_pend;
   ebi_buf #(.W($bits(ebi_pkg::ebi_req_s))) u_buf (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   (req_data),
      .out_valid (buf_v),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   // ***************************************************
   // Transaction sequencer
   // ***************************************************
   logic        sec_q, sec_d, bm_q, bm_d, rv_q, rv_d;
   logic [15:0] rd_q, rd_d;
   assign io_kind = cur_q.kind == ebi_pkg::K_IO
                 || cur_q.kind == ebi_pkg::K_IRQ_ACK_INDICATION;
   assign stp = (io_kind && io_en) ? p_rise : r_rise;

   always_comb begin
      st_d  = st_q;
      cur_d = cur_q;
      sec_d = sec_q;
      bm_d  = bm_q;
      rd_d  = rd_q;
      rv_d  = 1'b0;
      case (st_q)
         ebi_pkg::ST_IDLE: begin
            if (req_pend) begin
               st_d = ebi_pkg::ST_GRANT;
            end else if (buf_v) begin
               cur_d = buf_data;
               sec_d = 1'b0;
               st_d  = ebi_pkg::ST_T1;
            end
         end
         ebi_pkg::ST_T1: begin
            if (stp) st_d = ebi_pkg::ST_T2;
         end
         ebi_pkg::ST_T2: begin
            if (stp) begin
               bm_d = byte_mem;
               st_d = ebi_pkg::ST_T3;
            end
         end
         ebi_pkg::ST_T3: begin
            if (stp) begin
               if (cur_q.kind == ebi_pkg::K_MEM && cur_q.word && bm_q
                   && !sec_q) begin
                  rd_d[7:0] = din[7:0];
                  sec_d     = 1'b1;
                  st_d      = ebi_pkg::ST_T1;
               end else begin
                  if (sec_q) rd_d[15:8] = din[7:0];
                  else if (cur_q.word) rd_d = din;
                  else if (cur_q.addr[0]) rd_d = {8'h00, din[15:8]};
                  else rd_d = {8'h00, din[7:0]};
                  rv_d = 1'b1;
                  st_d = ebi_pkg::ST_IDLE;
               end
            end
         end
         ebi_pkg::ST_GRANT: begin
            if (!req_pend) st_d = ebi_pkg::ST_IDLE;
         end
         default: st_d = ebi_pkg::ST_IDLE;
      endcase
   end

   // ***************************************************
   // Pin drive values
   // ***************************************************
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] dout;
      logic        doe, lo_n, hi_n, mrd_n, mwr_n;
      logic        periph_request_n_n, periph_read_strobe_n_n, iowr_n, m1_n, oe, ack_n;
   } ebi_pins_s;
   ebi_pins_s pin_q, pin_d;
   logic act, strb, mem, wd;
   always_comb begin
      act  = st_d inside {ebi_pkg::ST_T1, ebi_pkg::ST_T2, ebi_pkg::ST_T3};
      strb = st_d inside {ebi_pkg::ST_T2, ebi_pkg::ST_T3};
      mem  = cur_d.kind == ebi_pkg::K_MEM || cur_d.kind == ebi_pkg::K_REFR;
      wd   = cur_d.word || cur_d.kind == ebi_pkg::K_REFR;
      pin_d.addr   = {cur_d.addr[23:1], cur_d.addr[0] | sec_d};
      pin_d.lo_n   = !(act && mem && (sec_d || wd || !cur_d.addr[0]));
      pin_d.hi_n   = !(act && mem && !sec_d && (wd || cur_d.addr[0]));
      pin_d.periph_request_n_n = !(act && cur_d.kind inside {ebi_pkg::K_IO,
                                                 ebi_pkg::K_IRQ_ACK_INDICATION});
      pin_d.m1_n   = !(act && (cur_d.kind == ebi_pkg::K_IRQ_ACK_INDICATION
                      || (cur_d.kind == ebi_pkg::K_MEM && cur_d.fetch)));
      pin_d.mrd_n  = !(strb && cur_d.kind == ebi_pkg::K_MEM && !cur_d.write);
      pin_d.mwr_n  = !(strb && cur_d.kind == ebi_pkg::K_MEM && cur_d.write);
      pin_d.periph_read_strobe_n_n = !(strb && cur_d.kind == ebi_pkg::K_IO && !cur_d.write);
      pin_d.iowr_n = !(strb && cur_d.kind == ebi_pkg::K_IO && cur_d.write);
      pin_d.doe    = strb && cur_d.write && cur_d.kind inside {ebi_pkg::K_MEM,
                                                                ebi_pkg::K_IO};
      if (sec_d) pin_d.dout = {8'h00, cur_d.wdata[15:8]};
      else if (cur_d.word) pin_d.dout = cur_d.wdata;
      else pin_d.dout = {cur_d.wdata[7:0], cur_d.wdata[7:0]};
      pin_d.oe     = st_d != ebi_pkg::ST_GRANT;
      pin_d.ack_n  = st_d != ebi_pkg::ST_GRANT;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q  <= ebi_pkg::ST_IDLE;
         cur_q <= '0;
         sec_q <= 1'b0;
         bm_q  <= 1'b0;
         rd_q  <= 16'h0000;
         rv_q  <= 1'b0;
         pin_q <= {40'h0, 1'b0, 8'hFF, 1'b1, 1'b1};
      end else begin
         st_q  <= st_d;
         cur_q <= cur_d;
         sec_q <= sec_d;
         bm_q  <= bm_d;
         rd_q  <= rd_d;
         rv_q  <= rv_d;
         pin_q <= pin_d;
      end
   end

   assign addr_out              = pin_q.addr;
   assign data_lines_out        = pin_q.dout;
   assign data_lines_oe         = pin_q.doe && pin_q.oe;
   assign low_lane_enable_n     = pin_q.lo_n;
   assign high_lane_enable_n    = pin_q.hi_n;
   assign mem_read_n            = pin_q.mrd_n;
   assign mem_write_n           = pin_q.mwr_n;
   assign periph_request_n      = pin_q.periph_request_n_n;
   assign periph_read_strobe_n  = pin_q.periph_read_strobe_n_n;
   assign periph_write_strobe_n = pin_q.iowr_n;
   assign opcode_fetch_cycle_n  = pin_q.m1_n;
   assign bus_oe                = pin_q.oe;
   assign bus_grant_ack_n       = pin_q.ack_n;
   assign resp_valid            = rv_q;
   assign resp_data             = rd_q;

   // ***************************************************
   // Status pins
   // ***************************************************
   logic [1:0] md_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) md_q <= 2'h0;
      else md_q <= cpu_mode;
   end
   assign standby_status_n = !md_q[1];
   assign halt_status_n    = !md_q[0];

   // ***************************************************
   // Interrupt conditioning
   // ***************************************************
   logic [3:1] lvl;
   genvar gi;
   generate
      for (gi = 1; gi <= 3; gi++) begin : g_irq
         logic       pnd_q, pnd_d, now, prv;
         logic [1:0] sn;
         always_comb begin
            sn    = ctrl_q[ebi_pkg::CTRL_SENSE_LSB + 2*(gi-1) +: 2];
            now   = sy2_q[gi];
            prv   = sy3_q[gi];
            pnd_d = pnd_q && !irq_clear[gi];
            if ((sn == ebi_pkg::SENSE_FALL && prv && !now)
                || (sn == ebi_pkg::SENSE_RISE && !prv && now)) begin
               pnd_d = 1'b1;
            end
            case (sn)
               ebi_pkg::SENSE_LOW:  lvl[gi] = !now;
               ebi_pkg::SENSE_HIGH: lvl[gi] = now;
               default:             lvl[gi] = pnd_q;
            endcase
         end
         always_ff @(posedge clk_sys) begin
            if (!rstn) pnd_q <= 1'b0;
            else pnd_q <= pnd_d;
         end
      end
   endgenerate
   assign core_irq    = req_pend ? 3'h0 : lvl;
   assign core_irq0_n = req_pend
                     || !(!sy2_q[0] || mimic_irq || dma_irq || hdlc_irq);

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_split_end;
      st_q == ebi_pkg::ST_T3 && stp && !sec_q && bm_q
         && cur_q.kind == ebi_pkg::K_MEM && cur_q.word;
   endsequence
   property p_split;
      s_split_end |=> st_q == ebi_pkg::ST_T1 && sec_q
         ##1 !low_lane_enable_n && high_lane_enable_n;
   endproperty
   a_split: assert property (p_split) else $error("no second byte");
   property p_wlanes;
      st_q == ebi_pkg::ST_T1 && !sec_q && cur_q.word
         && cur_q.kind == ebi_pkg::K_MEM
         |-> !low_lane_enable_n && !high_lane_enable_n;
   endproperty
   a_wlanes: assert property (p_wlanes) else $error("lanes off");
   property p_odd;
      st_q == ebi_pkg::ST_T1 && !cur_q.word && cur_q.addr[0]
         && cur_q.kind == ebi_pkg::K_MEM
         |-> low_lane_enable_n && !high_lane_enable_n;
   endproperty
   a_odd: assert property (p_odd) else $error("odd lane wrong");
   property p_even;
      st_q == ebi_pkg::ST_T2 && !cur_q.word && !cur_q.addr[0]
         && cur_q.kind == ebi_pkg::K_MEM |-> !low_lane_enable_n;
   endproperty
   a_even: assert property (p_even) else $error("even lane off");
   property p_prec;
      req_pend |-> core_irq == 3'h0 && core_irq0_n;
   endproperty
   a_prec: assert property (p_prec) else $error("irq passed");
   property p_grant;
      st_q == ebi_pkg::ST_GRANT |-> !bus_grant_ack_n && !bus_oe;
   endproperty
   a_grant: assert property (p_grant) else $error("bus not floated");
   property p_periph_request_n;
      st_q inside {ebi_pkg::ST_T2, ebi_pkg::ST_T3} && io_kind
         |-> !periph_request_n;
   endproperty
   a_periph_request_n: assert property (p_periph_request_n) else $error("io request off");
   property p_periph_read_strobe_n;
      st_q == ebi_pkg::ST_T3 && cur_q.kind == ebi_pkg::K_IO && !cur_q.write
         |-> !periph_read_strobe_n;
   endproperty
   a_periph_read_strobe_n: assert property (p_periph_read_strobe_n) else $error("io read off");
   property p_iostep;
      st_q == ebi_pkg::ST_T1 && io_kind && !io_en && !r_rise
         |=> st_q == ebi_pkg::ST_T1;
   endproperty
   a_iostep: assert property (p_iostep) else $error("io stepped");
   property p_stat;
      ##1 standby_status_n == !$past(cpu_mode[1])
         && halt_status_n == !$past(cpu_mode[0]);
   endproperty
   a_stat: assert property (p_stat) else $error("status pins");
endmodule

// File: ebi_pkg.sv
package ebi_pkg;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [3:0]  REG_CTRL       = 4'h0;
   localparam logic [3:0]  REG_STAT       = 4'h4;
   localparam int          CTRL_W         = 11;
   localparam logic [10:0] CTRL_RST       = 11'h010;
   localparam int          CTRL_RATIO_LSB = 0;
   localparam int          CTRL_IODIV_LSB = 2;
   localparam int          CTRL_IOEN_BIT  = 4;
   localparam int          CTRL_SENSE_LSB = 5;
   // ***************************************************
   // Clock ratios, timing and interrupt sense codes
   // ***************************************************
   localparam int         SYS_NS       = 20;
   localparam int         OSC_NS       = 80;
   localparam logic [2:0] OSC_HALF_CYC = 3'((OSC_NS / SYS_NS) / 2);
   localparam logic [1:0] RATIO_EQ     = 2'h0;
   localparam logic [1:0] RATIO_HALF   = 2'h1;
   localparam logic [1:0] RATIO_DBL    = 2'h2;
   localparam logic [1:0] SENSE_LOW    = 2'h0;
   localparam logic [1:0] SENSE_HIGH   = 2'h1;
   localparam logic [1:0] SENSE_FALL   = 2'h2;
   localparam logic [1:0] SENSE_RISE   = 2'h3;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_T1    = 3'h1,
      ST_T2    = 3'h2,
      ST_T3    = 3'h3,
      ST_GRANT = 3'h4
   } ebi_state_e;
   typedef enum logic [1:0] {
      K_MEM    = 2'h0,
      K_IO     = 2'h1,
      K_IRQ_ACK_INDICATION = 2'h2,
      K_REFR   = 2'h3
   } ebi_kind_e;
   typedef struct packed {
      ebi_kind_e   kind;
      logic        write;
      logic        word;
      logic        fetch;
      logic [23:0] addr;
      logic [15:0] wdata;
   } ebi_req_s;
endpackage

// File: ebi_div.sv
`timescale 1ns/1ns
module ebi_div #(
   parameter int CNT_W = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             en,
   input  wire logic [CNT_W-1:0] half,
   output logic                  clk_out,
   output logic                  rise
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             lvl_q;
   logic             lvl_d;
   logic             wrap;

   // ***************************************************
   // Half-period counter in enable ticks
   // ***************************************************
   always_comb begin
      wrap  = en && (cnt_q + 1'b1 >= half);
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      if (wrap) begin
         cnt_d = '0;
         lvl_d = !lvl_q;
      end else if (en) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign clk_out = lvl_q;
   assign rise    = wrap && !lvl_q;
endmodule

// File: ebi_buf.sv
`timescale 1ns/1ns
module ebi_buf #(
   parameter int W = 45
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_q [2];
   logic [W-1:0] mem_d [2];
   logic         wp_q, wp_d, rp_q, rp_d;
   logic [1:0]   cnt_q, cnt_d;
   logic         push, pop;

   // ***************************************************
   // Two-entry ring
   // ***************************************************
   always_comb begin
      in_ready  = cnt_q != 2'h2;
      out_valid = cnt_q != 2'h0;
      out_data  = mem_q[rp_q];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      mem_d     = mem_q;
      wp_d      = wp_q ^ push;
      rp_d      = rp_q ^ pop;
      cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};
      if (push) begin
         mem_d[wp_q] = in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      mem_q <= mem_d;
      if (!rstn) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// File: ebi_mem.sv
`timescale 1ns/1ns
// Memory and peripheral model at the pins
module ebi_mem (
   input  wire logic        clk_sys,
   input  wire logic        byte_mode,
   input  wire logic [23:0] addr_out,
   input  wire logic [15:0] data_lines_out,
   input  wire logic        data_lines_oe,
   input  wire logic        mem_read_n,
   input  wire logic        mem_write_n,
   input  wire logic        periph_read_strobe_n,
   input  wire logic        periph_request_n,
   input  wire logic        opcode_fetch_cycle_n,
   output logic             mem_width_byte_n,
   output logic [15:0]      data_lines_in,
   output logic             irq_ack_n,
   output logic [15:0]      wr_q
);
   logic [15:0] last_q = 16'h0000;
   logic [7:0]  lo_b;
   logic [7:0]  hi_b;
   logic        act;
   assign act = !mem_read_n || !periph_read_strobe_n;
   assign lo_b = {addr_out[7:1], byte_mode & addr_out[0]} ^ 8'h3C;
   assign hi_b = {addr_out[7:1], 1'b1} ^ 8'h3C;
   assign mem_width_byte_n = !byte_mode;
   assign irq_ack_n = opcode_fetch_cycle_n | periph_request_n;
   // Released lines show the inverse of the last value
   assign data_lines_in = !act ? ~last_q :
                          byte_mode ? {~lo_b, lo_b} : {hi_b, lo_b};
   always @(posedge clk_sys) begin
      if (act)
         last_q <= data_lines_in;
      if (!mem_write_n && data_lines_oe)
         wr_q <= data_lines_out;
   end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
   logic        clk_sys, rstn, reg_wr, reg_rd, req_valid, req_ready;
   logic        resp_valid, mimic_irq, dma_irq, hdlc_irq, core_irq0_n;
   logic        irq_in_zero_n, ext_master_request_n, bus_grant_ack_n;
   logic        mem_width_byte_n, bus_ref_clk, periph_xfer_clk, byte_mode;
   logic        low_lane_enable_n, high_lane_enable_n, mem_read_n;
   logic        mem_write_n, periph_request_n, periph_read_strobe_n;
   logic        opcode_fetch_cycle_n, bus_oe, standby_status_n;
   logic        halt_status_n, data_lines_oe, irq_ack_n, byte_acc;
   logic [1:0]  cpu_mode;
   logic [2:0]  e;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [15:0] resp_data, data_lines_in, data_lines_out, wr_q;
   logic [23:0] addr_out;
   logic [3:1]  irq_clear, core_irq, irq_in_n;
   ebi_pkg::ebi_req_s req_data;
   int          err_total, total_checks, lo_n, hi_n, rq_n, io_rd, pk_n, n;
   int          ia_n;
   localparam int          PD   = ebi_pkg::OSC_NS / ebi_pkg::SYS_NS;
   localparam logic [11:0] SEXP = 12'b010_110_011_100;

   ebi_top i_ebi_top (.*, .periph_write_strobe_n());
   ebi_mem i_ebi_mem (.*);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ****************
   // Monitors
   // ****************
   always @(posedge clk_sys) begin
      lo_n += int'($fell(low_lane_enable_n));
      hi_n += int'($fell(high_lane_enable_n));
      rq_n += int'($fell(periph_request_n));
      pk_n += int'($changed(periph_xfer_clk));
      ia_n += int'($fell(irq_ack_n));
      io_rd += int'(!periph_read_strobe_n && !periph_request_n);
   end
   // ****************
   // Tasks
   // ****************
   task end_sim;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
      total_checks++;
      if (got !== ex) begin
         err_total++;
         $display("Error %s exp %h got %h", nm, ex, got);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a);
      @(posedge clk_sys);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask
   task go(input ebi_pkg::ebi_kind_e k, input logic w, input logic [23:0] a);
      {lo_n, hi_n, rq_n, io_rd, pk_n, ia_n} = '0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_data <= '{k, w, !byte_acc, 1'b0, a, 16'hBEEF};
      #1;
      while (req_ready !== 1'b1)
         tick(1);
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   task wresp;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (resp_valid !== 1'b1 && n < 2000);
      chk("resp_valid", resp_valid, 1'b1);
   endtask
   task meas(input bit s);
      logic p;
      logic c;
      int   k;
      k = 0;
      n = 0;
      c = s ? periph_xfer_clk : bus_ref_clk;
      while (k < 2 && n < 200) begin
         p = c;
         tick(1);
         c = s ? periph_xfer_clk : bus_ref_clk;
         n += int'(k == 1);
         k += int'(c && !p);
      end
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      {rstn, reg_wr, reg_rd, req_valid, mimic_irq, dma_irq, hdlc_irq} = '0;
      {irq_in_zero_n, ext_master_request_n, irq_in_n} = 5'h1F;
      {byte_acc, byte_mode, cpu_mode, irq_clear, reg_addr, reg_wdata} = '0;
      {err_total, total_checks, lo_n, hi_n, rq_n, io_rd, pk_n, ia_n} = '0;
      req_data = '0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      tick(1);
      chk("ack_n", bus_grant_ack_n, 1'b1);
      rreg(ebi_pkg::REG_CTRL);
      chk("ctrl", rd, 32'(ebi_pkg::CTRL_RST));
      rreg(ebi_pkg::REG_STAT);
      chk("stat", rd, 32'h0);
      wreg(4'h8, 32'h7FF);
      rreg(4'h8);
      chk("unmapped", rd, 32'h0);
      $display("registers done");
      for (bit [2:0] m = 0; m < 4; m++) begin
         @(posedge clk_sys);
         cpu_mode <= m[1:0];
         tick(3);
         chk("status_n", {standby_status_n, halt_status_n}, 2'(~m[1:0]));
      end
      for (bit [2:0] i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         {irq_in_zero_n, hdlc_irq, dma_irq, mimic_irq} <= 4'h8 ^ (4'h1 << i);
         tick(5);
         chk("irq0_n", core_irq0_n, i == 4);
      end
      for (bit [2:0] m = 0; m < 4; m++) begin
         e = SEXP[3*m +: 3];
         wreg(ebi_pkg::REG_CTRL, {21'h0, {3{m[1:0]}}, 5'h10});
         @(posedge clk_sys);
         irq_in_n <= 3'h0;
         tick(5);
         chk("irq_fall", core_irq, {3{e[2]}});
         irq_in_n <= 3'h7;
         tick(5);
         chk("irq_rise", core_irq, {3{e[1]}});
         irq_clear <= 3'h7;
         tick(1);
         irq_clear <= 3'h0;
         tick(3);
         chk("irq_clr", core_irq, {3{e[0]}});
      end
      $display("status and interrupts done");
      for (bit [2:0] m = 0; m < 3; m++) begin
         wreg(ebi_pkg::REG_CTRL, {27'h0, 3'h4, m[1:0]});
         meas(0);
         meas(0);
         chk("bus_clk", n, m == 2 ? PD / 2 : PD << m);
      end
      for (bit [2:0] d = 0; d < 4; d++) begin
         wreg(ebi_pkg::REG_CTRL, {27'h0, 1'b1, d[1:0], 2'h0});
         meas(1);
         meas(1);
         chk("io_clk", n, PD * 2 * (d + 1));
      end
      $display("clocks done");
      for (bit [1:0] b = 0; b < 2; b++) begin
         @(posedge clk_sys);
         byte_mode <= b[0];
         go(ebi_pkg::K_MEM, 1'b0, 24'h000010);
         wresp;
         chk("rdata", resp_data, 16'h2D2C);
         chk("lo_lane", lo_n, 1);
         chk("hi_lane", hi_n, 1);
      end
      byte_mode <= 1'b0;
      go(ebi_pkg::K_MEM, 1'b1, 24'h000020);
      wresp;
      chk("wdata", wr_q, 16'hBEEF);
      byte_acc = 1'b1;
      go(ebi_pkg::K_MEM, 1'b0, 24'h000011);
      wresp;
      chk("odd_byte", resp_data, 16'h002D);
      chk("odd_lanes", lo_n * 2 + hi_n, 1);
      go(ebi_pkg::K_MEM, 1'b0, 24'h000010);
      wresp;
      chk("even_byte", resp_data, 16'h002C);
      chk("even_lanes", lo_n * 2 + hi_n, 2);
      byte_acc = 1'b0;
      $display("memory done");
      for (bit [1:0] b = 0; b < 2; b++) begin
         wreg(ebi_pkg::REG_CTRL, {27'h0, ~b[0], 4'h0});
         tick(1);
         go(ebi_pkg::K_IO, 1'b0, 24'h000040);
         wresp;
         chk("io_strobe", io_rd > 0, 1'b1);
         chk("io_req", rq_n, 1);
         chk("io_clk_idle", pk_n == 0, b[0]);
         chk("io_ack", ia_n, 0);
      end
      go(ebi_pkg::K_IRQ_ACK_INDICATION, 1'b0, 24'h000000);
      wresp;
      chk("ack_req", rq_n, 1);
      chk("ack_ind", ia_n, 1);
      $display("io done");
      @(posedge clk_sys);
      ext_master_request_n <= 1'b0;
      dma_irq <= 1'b1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (bus_grant_ack_n !== 1'b0 && n < 20);
      tick(1);
      chk("grant", {bus_grant_ack_n, bus_oe}, 2'b00);
      go(ebi_pkg::K_MEM, 1'b0, 24'h000010);
      tick(40);
      chk("held", lo_n + int'(resp_valid), 0);
      chk("irq_masked", core_irq0_n, 1'b1);
      ext_master_request_n <= 1'b1;
      dma_irq <= 1'b0;
      wresp;
      chk("rdata", resp_data, 16'h2D2C);
      $display("grant done");
      end_sim;
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_total++;
      end_sim;
   end
endmodule
